// ---- hw/arf_top.sv ----
// converter result formatter: apb registers, conversion sequencing, result packing, interrupt
// assumes the analog front end presents a settled signed 13-bit value on conv_value
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module arf_top #(
  parameter int CONV_TICKS = arf_pkg::CONV_TICKS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [12:0] conv_value,
  output logic             conv_enable,
  output logic             conv_busy,
  output logic      [4:0]  positive_channel_select,
  output logic      [3:0]  negative_channel_select,
  output logic             irq
);

  arf_res_if res ();

  arf_pkg::arf_state_e state_q, state_d;
  logic [7:0]  ctrl0_q, ctrl0_d;
  logic [7:0]  ctrl1_q, ctrl1_d;
  logic [7:0]  ctrl2_q, ctrl2_d;
  logic [7:0]  mask_q, mask_d;
  logic        done_flag_q, done_flag_d;
  logic [7:0]  res_high_q, res_high_d;
  logic [7:0]  res_low_q, res_low_d;
  logic [5:0]  pre_q, pre_d;
  logic [4:0]  tick_cnt_q, tick_cnt_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic        irq_q, irq_d;
  logic        access, wr_ok, rd_ok, mapped;
  logic        tick, conv_done;
  logic [5:0]  div_m1;
  logic [7:0]  rd_byte;

  // ---------------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------------
  always_comb begin
    access = psel & penable & pready_q;
    unique case (paddr)
      arf_pkg::OFF_CTRL0, arf_pkg::OFF_CTRL1, arf_pkg::OFF_CTRL2,
      arf_pkg::OFF_RES_HIGH, arf_pkg::OFF_RES_LOW,
      arf_pkg::OFF_IRQ_STAT, arf_pkg::OFF_IRQ_MASK: mapped = 1'b1;
      default:                                      mapped = 1'b0;
    endcase
    wr_ok = access & pwrite & mapped;
    rd_ok = access & ~pwrite & mapped;
  end

  // ---------------------------------------------------------------------------
  // conversion clock divider
  // ---------------------------------------------------------------------------
  always_comb begin
    unique case (ctrl1_q[arf_pkg::CTRL1_CS_LSB +: 3])
      3'h0:    div_m1 = 6'h01;
      3'h1:    div_m1 = 6'h07;
      3'h2:    div_m1 = 6'h1f;
      3'h3:    div_m1 = arf_pkg::FRC_DIV_M1;
      3'h4:    div_m1 = 6'h03;
      3'h5:    div_m1 = 6'h0f;
      3'h6:    div_m1 = 6'h3f;
      3'h7:    div_m1 = arf_pkg::FRC_DIV_M1;
    endcase
    tick      = (state_q == arf_pkg::ARF_CONVERT) && (pre_q == div_m1);
    conv_done = tick && (tick_cnt_q == 5'(CONV_TICKS - 1));
  end

  // ---------------------------------------------------------------------------
  // result packer
  // ---------------------------------------------------------------------------
  assign res.value    = conv_value;
  assign res.fmt_twos = ctrl1_q[arf_pkg::CTRL1_FMT_BIT];

  arf_packer u_packer (
    .res (res)
  );

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    ctrl0_d     = ctrl0_q;
    ctrl1_d     = ctrl1_q;
    ctrl2_d     = ctrl2_q;
    mask_d      = mask_q;
    res_high_d  = res_high_q;
    res_low_d   = res_low_q;
    pre_d       = pre_q;
    tick_cnt_d  = tick_cnt_q;
    done_flag_d = done_flag_q;

    if (wr_ok) begin
      unique case (paddr)
        arf_pkg::OFF_CTRL0:    ctrl0_d = pwdata[7:0];
        arf_pkg::OFF_CTRL1:    ctrl1_d = pwdata[7:0];
        arf_pkg::OFF_CTRL2:    ctrl2_d = pwdata[7:0];
        arf_pkg::OFF_RES_HIGH: res_high_d = pwdata[7:0];
        arf_pkg::OFF_RES_LOW:  res_low_d = pwdata[7:0];
        arf_pkg::OFF_IRQ_MASK: mask_d = pwdata[7:0];
        default:               ;
      endcase
    end
    ctrl1_d[arf_pkg::CTRL1_RSV_BIT] = 1'b0;

    // start flag lives in the state; a write sets or aborts it
    unique case (state_q)
      arf_pkg::ARF_IDLE: begin
        pre_d      = 6'h00;
        tick_cnt_d = 5'h00;
        if (wr_ok && paddr == arf_pkg::OFF_CTRL0 && pwdata[arf_pkg::CTRL0_GO_BIT] &&
            pwdata[arf_pkg::CTRL0_ON_BIT]) begin
          state_d = arf_pkg::ARF_CONVERT;
        end
      end
      arf_pkg::ARF_CONVERT: begin
        pre_d = tick ? 6'h00 : 6'(pre_q + 6'h01);
        if (tick) begin
          tick_cnt_d = 5'(tick_cnt_q + 5'h01);
        end
        if (conv_done) begin
          state_d     = arf_pkg::ARF_IDLE;
          res_high_d  = res.high_byte;
          res_low_d   = res.low_byte;
        end else if (!ctrl0_d[arf_pkg::CTRL0_ON_BIT] ||
                     (wr_ok && paddr == arf_pkg::OFF_CTRL0 && !pwdata[arf_pkg::CTRL0_GO_BIT])) begin
          state_d = arf_pkg::ARF_IDLE;
        end
      end
    endcase
    ctrl0_d[arf_pkg::CTRL0_GO_BIT] = (state_d == arf_pkg::ARF_CONVERT);

    // sticky done flag; a read of the status clears it, a new completion wins
    if (rd_ok && paddr == arf_pkg::OFF_IRQ_STAT) begin
      done_flag_d = 1'b0;
    end
    if (conv_done) begin
      done_flag_d = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // bus answer and interrupt
  // ---------------------------------------------------------------------------
  always_comb begin
    pready_d  = psel & penable & ~pready_q;
    pslverr_d = pready_d & ~mapped;
    unique case (paddr)
      arf_pkg::OFF_CTRL0:    rd_byte = ctrl0_q;
      arf_pkg::OFF_CTRL1:    rd_byte = ctrl1_q;
      arf_pkg::OFF_CTRL2:    rd_byte = ctrl2_q;
      arf_pkg::OFF_RES_HIGH: rd_byte = res_high_q;
      arf_pkg::OFF_RES_LOW:  rd_byte = res_low_q;
      arf_pkg::OFF_IRQ_STAT: rd_byte = {7'h00, done_flag_q | conv_done};
      arf_pkg::OFF_IRQ_MASK: rd_byte = mask_q;
      default:               rd_byte = 8'h00;
    endcase
    prdata_d = (pready_d && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    irq_d    = done_flag_d & mask_d[arf_pkg::IRQ_DONE_BIT];
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= arf_pkg::ARF_IDLE;
      ctrl0_q     <= arf_pkg::RST_CTRL0;
      ctrl1_q     <= arf_pkg::RST_CTRL1;
      ctrl2_q     <= arf_pkg::RST_CTRL2;
      mask_q      <= arf_pkg::RST_IRQ_MASK;
      done_flag_q <= 1'b0;
      pre_q       <= 6'h00;
      tick_cnt_q  <= 5'h00;
      prdata_q    <= 32'h00000000;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      ctrl0_q     <= ctrl0_d;
      ctrl1_q     <= ctrl1_d;
      ctrl2_q     <= ctrl2_d;
      mask_q      <= mask_d;
      done_flag_q <= done_flag_d;
      pre_q       <= pre_d;
      tick_cnt_q  <= tick_cnt_d;
      prdata_q    <= prdata_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
      irq_q       <= irq_d;
    end
  end

  // result bytes keep their contents through reset
  always_ff @(posedge pclk) begin
    res_high_q <= res_high_d;
    res_low_q  <= res_low_d;
  end

  assign prdata                  = prdata_q;
  assign pready                  = pready_q;
  assign pslverr                 = pslverr_q;
  assign conv_enable             = ctrl0_q[arf_pkg::CTRL0_ON_BIT];
  assign conv_busy               = ctrl0_q[arf_pkg::CTRL0_GO_BIT];
  assign positive_channel_select = ctrl0_q[arf_pkg::CTRL0_CHP_LSB +: 5];
  assign negative_channel_select = ctrl2_q[arf_pkg::CTRL2_CHN_LSB +: 4];
  assign irq                     = irq_q;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  logic [12:0] ast_neg;
  logic [11:0] ast_mag;
  always_comb begin
    ast_neg = 13'(~conv_value + 13'h0001);
    ast_mag = !conv_value[12] ? conv_value[11:0] : (ast_neg[12] ? 12'hfff : ast_neg[11:0]);
  end

  default clocking ast_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_end_sm;
    conv_done && !ctrl1_q[arf_pkg::CTRL1_FMT_BIT];
  endsequence

  sequence s_end_tc;
    conv_done && ctrl1_q[arf_pkg::CTRL1_FMT_BIT];
  endsequence

  AST_SM_HIGH: assert property (s_end_sm |=> res_high_q == $past(ast_mag[11:4]))
    else $error("sign-magnitude high byte wrong");
  AST_SM_LOW_MAG: assert property (s_end_sm |=> res_low_q[7:4] == $past(ast_mag[3:0]))
    else $error("sign-magnitude low nibble wrong");
  AST_SM_ZERO: assert property (s_end_sm |=> res_low_q[3:1] == 3'h0)
    else $error("sign-magnitude pad bits not zero");
  AST_SM_SIGN: assert property (s_end_sm |=> res_low_q[0] == $past(conv_value[12]))
    else $error("sign-magnitude sign bit wrong");
  AST_TC_EXT: assert property (s_end_tc |=> res_high_q[7:4] == {4{$past(conv_value[12])}})
    else $error("twos-complement sign extension wrong");
  AST_TC_HIGH: assert property (s_end_tc |=> res_high_q[3:0] == $past(conv_value[11:8]))
    else $error("twos-complement high nibble wrong");
  AST_TC_LOW: assert property (s_end_tc |=> res_low_q == $past(conv_value[7:0]))
    else $error("twos-complement low byte wrong");
  AST_GO_CLEAR: assert property (conv_done |=> !conv_busy && done_flag_q && state_q == arf_pkg::ARF_IDLE)
    else $error("start flag not cleared at completion");
  AST_ATOMIC: assert property ($rose(done_flag_q) |-> $fell(conv_busy) && $past(conv_done))
    else $error("done flag rose apart from completion");
  AST_RES_WRITE: assert property (wr_ok && paddr == arf_pkg::OFF_RES_HIGH && !conv_done
                                  |=> res_high_q == $past(pwdata[7:0]))
    else $error("result high byte write lost");
  AST_FMT_SEL: assert property (wr_ok && paddr == arf_pkg::OFF_CTRL1
                                |=> res.fmt_twos == $past(pwdata[arf_pkg::CTRL1_FMT_BIT]))
    else $error("format select not taken");
  AST_CONV_LEN: assert property ($rose(conv_busy) |-> !conv_done [*2])
    else $error("conversion ended too early");

  // ---------------------------------------------------------------------------
  // bus, abort and interrupt checks
  // ---------------------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_wait;
    psel && penable && !pready_q;
  endsequence

  sequence s_wait_unmapped;
    psel && penable && !pready_q && !mapped;
  endsequence

  sequence s_wait_mapped;
    psel && penable && !pready_q && mapped;
  endsequence

  sequence s_wait_stat;
    psel && penable && !pready_q && !pwrite && paddr == arf_pkg::OFF_IRQ_STAT;
  endsequence

  sequence s_stat_clear;
    rd_ok && paddr == arf_pkg::OFF_IRQ_STAT && !conv_done;
  endsequence

  sequence s_start;
    state_q == arf_pkg::ARF_IDLE && wr_ok && paddr == arf_pkg::OFF_CTRL0 &&
    pwdata[arf_pkg::CTRL0_GO_BIT] && pwdata[arf_pkg::CTRL0_ON_BIT];
  endsequence

  // clearing either enable or start while busy drops the conversion
  sequence s_abort;
    state_q == arf_pkg::ARF_CONVERT && wr_ok && paddr == arf_pkg::OFF_CTRL0 && !conv_done &&
    !(pwdata[arf_pkg::CTRL0_GO_BIT] && pwdata[arf_pkg::CTRL0_ON_BIT]);
  endsequence

  AST_BUS_WALK: assert property (s_setup ##1 s_wait |=> pready)
    else $error("no ready after one wait state");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_ERR_UNMAPPED: assert property (s_wait_unmapped |=> pready && pslverr && prdata == 32'h00000000)
    else $error("unmapped access not flagged");
  AST_ERR_MAPPED: assert property (s_wait_mapped |=> pready && !pslverr)
    else $error("mapped access flagged as error");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h00000000 && !pslverr)
    else $error("bus answer outside the ready cycle");
  AST_RDATA_UPPER: assert property (prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_STAT_READ: assert property (s_wait_stat |=> prdata[0] == $past(done_flag_q || conv_done))
    else $error("status read does not show the done flag");
  AST_STAT_CLEAR: assert property (s_stat_clear |=> !done_flag_q)
    else $error("status read did not clear the done flag");
  AST_IRQ_LEVEL: assert property (irq == (done_flag_q && mask_q[arf_pkg::IRQ_DONE_BIT]))
    else $error("interrupt level differs from flag and mask");
  AST_START: assert property (s_start |=> conv_busy && conv_enable)
    else $error("start write did not begin a conversion");
  AST_ABORT: assert property (s_abort |=> !conv_busy && $stable(done_flag_q))
    else $error("aborted conversion kept running or flagged");
  AST_DONE_BUSY: assert property (conv_done |-> conv_busy && conv_enable)
    else $error("completion outside a running conversion");

endmodule : arf_top

// ---- inc/arf_pkg.sv ----
// shared constants for the converter result formatter: register map, fields, resets, states
// assumes a 32-bit apb slave with byte addresses and one 8-bit register per aligned word
package arf_pkg;

  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFF_CTRL0     = 8'h00;
  localparam logic [7:0]  OFF_CTRL1     = 8'h04;
  localparam logic [7:0]  OFF_CTRL2     = 8'h08;
  localparam logic [7:0]  OFF_RES_HIGH  = 8'h0c;
  localparam logic [7:0]  OFF_RES_LOW   = 8'h10;
  localparam logic [7:0]  OFF_IRQ_STAT  = 8'h14;
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'h18;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int          CTRL0_ON_BIT  = 0;
  localparam int          CTRL0_GO_BIT  = 1;
  localparam int          CTRL0_CHP_LSB = 2;
  localparam int          CTRL0_MODE_BIT = 7;
  localparam int          CTRL1_FMT_BIT = 7;
  localparam int          CTRL1_CS_LSB  = 4;
  localparam int          CTRL1_RSV_BIT = 3;
  localparam int          CTRL2_CHN_LSB = 0;
  localparam int          IRQ_DONE_BIT  = 0;

  // ---------------------------------------------------------------------------
  // reset values and timing counts
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  RST_CTRL0     = 8'h00;
  localparam logic [7:0]  RST_CTRL1     = 8'h00;
  localparam logic [7:0]  RST_CTRL2     = 8'h00;
  localparam logic [7:0]  RST_IRQ_MASK  = 8'h00;
  localparam int          CONV_TICKS    = 15;
  localparam logic [5:0]  FRC_DIV_M1    = 6'h0f;

  typedef enum logic [0:0] {
    ARF_IDLE    = 1'b0,
    ARF_CONVERT = 1'b1
  } arf_state_e;

endpackage : arf_pkg

// ---- inc/arf_res_if.sv ----
// carrier between the controller and the result packer
// assumes one clock domain; the packer is purely combinational
`timescale 1ns/1ps
interface arf_res_if;
  logic [12:0] value;
  logic        fmt_twos;
  logic [7:0]  high_byte;
  logic [7:0]  low_byte;

  modport src (output value, output fmt_twos, input high_byte, input low_byte);
  modport pack (input value, input fmt_twos, output high_byte, output low_byte);
endinterface : arf_res_if

// ---- hw/arf_packer.sv ----
// packs a signed 13-bit conversion value into the two result bytes
// assumes value is two's complement with bit 12 as the sign
`timescale 1ns/1ps
module arf_packer (
  arf_res_if.pack res
);

  logic [12:0] neg_val;
  logic [11:0] mag;

  // ---------------------------------------------------------------------------
  // magnitude, saturating the single value that has no positive twin
  // ---------------------------------------------------------------------------
  always_comb begin
    neg_val = 13'(~res.value + 13'h0001);
    if (!res.value[12]) begin
      mag = res.value[11:0];
    end else if (neg_val[12]) begin
      mag = 12'hfff;
    end else begin
      mag = neg_val[11:0];
    end
  end

  // ---------------------------------------------------------------------------
  // byte layout
  // ---------------------------------------------------------------------------
  always_comb begin
    if (res.fmt_twos) begin
      res.high_byte = {{4{res.value[12]}}, res.value[11:8]};
      res.low_byte  = res.value[7:0];
    end else begin
      res.high_byte = mag[11:4];
      res.low_byte  = {mag[3:0], 3'h0, res.value[12]};
    end
  end

endmodule : arf_packer

// ---- verification/arf_top_test.sv ----
// self-checking bench for the converter result formatter: apb master, conversions, result layouts
// assumes arf_pkg and arf_top are compiled first; the bench drives every input port of arf_top itself
`timescale 1ns/1ps
module arf_top_test;
  localparam int TICKS = 2;
  localparam int ACQ   = 6;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [12:0] conv_value;
  logic        conv_enable;
  logic        conv_busy;
  logic [4:0]  positive_channel_select;
  logic [3:0]  negative_channel_select;
  logic        irq;
  int          n_fail;
  int          tests_run;
  logic [31:0] rd;
  logic        err;
  logic [12:0] corner [5] = '{13'h0000, 13'h0001, 13'h0fff, 13'h1000, 13'h1fff};
  logic [7:0]  rst_off [4];

  arf_top #(.CONV_TICKS(TICKS)) dut (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .conv_value              (conv_value),
    .conv_enable             (conv_enable),
    .conv_busy               (conv_busy),
    .positive_channel_select (positive_channel_select),
    .negative_channel_select (negative_channel_select),
    .irq                     (irq)
  );

  // ---------------------------------------------------------------------------
  // clock, verdict, watchdog
  // ---------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic close_out;
    $display("mismatches=%0d comparisons=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  initial begin
    #1000000;
    n_fail++;
    $display("watchdog expired at %0t", $time);
    close_out();
  end

  // ---------------------------------------------------------------------------
  // shared tasks and expectations
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one full transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    check({31'h0, pready}, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // callers look at outputs only after the completing edge has settled
    @(negedge pclk);
  endtask : apb

  // expected {high byte, low byte} for a signed value in either layout
  function automatic logic [15:0] pack_exp(input logic [12:0] v, input logic fmt);
    logic [12:0] m;
    logic [11:0] mag;
    m   = v[12] ? (13'h0000 - v) : v;
    mag = m[12] ? 12'hfff : m[11:0];
    if (fmt) begin
      return {{4{v[12]}}, v[11:0]};
    end
    return {mag, 3'b000, v[12]};
  endfunction : pack_exp

  // pclk cycles per conversion tick for each clock select; oscillator codes use the modelled ratio
  function automatic int div_of(input logic [2:0] cs);
    case (cs)
      3'h0:    return 2;
      3'h1:    return 8;
      3'h2:    return 32;
      3'h4:    return 4;
      3'h5:    return 16;
      3'h6:    return 64;
      default: return int'(arf_pkg::FRC_DIV_M1) + 1;
    endcase
  endfunction : div_of

  task automatic convert(input logic [12:0] v, input logic fmt, input logic msk, input logic [2:0] cs);
    int          n;
    logic [15:0] e;
    e = pack_exp(v, fmt);
    apb(1'b1, arf_pkg::OFF_CTRL1, {24'h0, fmt, cs, 4'h0});
    apb(1'b1, arf_pkg::OFF_IRQ_MASK, {31'h0, msk});
    conv_value <= v;
    apb(1'b1, arf_pkg::OFF_CTRL0, 32'h0000_0001);
    repeat (ACQ) @(posedge pclk);
    apb(1'b1, arf_pkg::OFF_CTRL0, 32'h0000_0003);
    check({31'h0, conv_enable}, 32'h1);
    n = 0;
    while (n < 200) begin
      @(posedge pclk);
      if (conv_busy !== 1'b1) break;
      n++;
    end
    check(n, TICKS * div_of(cs));
    check({31'h0, irq}, {31'h0, msk});
    apb(1'b0, arf_pkg::OFF_CTRL0, 32'h0);
    check({31'h0, rd[1]}, 32'h0);
    apb(1'b0, arf_pkg::OFF_RES_HIGH, 32'h0);
    check(rd, {24'h0, e[15:8]});
    apb(1'b0, arf_pkg::OFF_RES_LOW, 32'h0);
    check(rd, {24'h0, e[7:0]});
    apb(1'b0, arf_pkg::OFF_IRQ_STAT, 32'h0);
    check({31'h0, rd[0]}, 32'h1);
    apb(1'b0, arf_pkg::OFF_IRQ_STAT, 32'h0);
    check({31'h0, rd[0]}, 32'h0);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
  endtask : convert

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [7:0] b;
    int         k;
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    conv_value = 13'h0000;
    n_fail     = 0;
    tests_run  = 0;
    rst_off    = '{arf_pkg::OFF_CTRL0, arf_pkg::OFF_CTRL1, arf_pkg::OFF_CTRL2, arf_pkg::OFF_IRQ_MASK};
    void'($urandom(32'h2385eb93));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_off[i]) begin
      apb(1'b0, rst_off[i], 32'h0);
      check(rd, 32'h0);
    end
    $display("test 1 done");
    apb(1'b0, 8'h1c, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, arf_pkg::OFF_CTRL1, 32'h0000_00ff);
    apb(1'b0, arf_pkg::OFF_CTRL1, 32'h0);
    check(rd, 32'h0000_00f7);
    apb(1'b1, arf_pkg::OFF_CTRL2, 32'h0000_00a5);
    check({28'h0, negative_channel_select}, 32'h5);
    apb(1'b1, arf_pkg::OFF_CTRL0, 32'h0000_007c);
    check({27'h0, positive_channel_select}, 32'h1f);
    $display("test 2 done");
    for (k = 0; k < 4; k++) begin
      b = 8'($urandom);
      apb(1'b1, arf_pkg::OFF_RES_HIGH, {24'h0, b});
      apb(1'b0, arf_pkg::OFF_RES_HIGH, 32'h0);
      check(rd, {24'h0, b});
      apb(1'b1, arf_pkg::OFF_RES_LOW, {24'h0, ~b});
      apb(1'b0, arf_pkg::OFF_RES_LOW, 32'h0);
      check(rd, {24'h0, ~b});
    end
    $display("test 3 done");
    foreach (corner[i]) begin
      convert(corner[i], 1'b0, 1'b1, 3'(i));
      convert(corner[i], 1'b1, 1'b0, 3'(i + 3));
    end
    $display("test 4 done");
    for (k = 0; k < 12; k++) begin
      convert(13'($urandom), 1'($urandom), 1'($urandom), 3'($urandom));
    end
    $display("test 5 done");
    // slowest clock select, so the abort lands long before completion
    apb(1'b1, arf_pkg::OFF_CTRL1, 32'h0000_0060);
    apb(1'b1, arf_pkg::OFF_CTRL0, 32'h0000_0003);
    check({31'h0, conv_busy}, 32'h1);
    apb(1'b1, arf_pkg::OFF_CTRL0, 32'h0000_0001);
    check({31'h0, conv_busy}, 32'h0);
    repeat (TICKS * 64) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    apb(1'b0, arf_pkg::OFF_IRQ_STAT, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, arf_pkg::OFF_CTRL0, 32'h0);
    check(rd, 32'h1);
    $display("test 6 done");
    close_out();
  end
endmodule : arf_top_test
